/* logic/wer_pkg.sv */
// package of constants and types for the wake event reset detector
package wer_pkg;
  // =========================================
  // widths
  localparam int unsigned EVENT_COUNT = 8;
  localparam int unsigned INDEX_WIDTH = 3;
  localparam int unsigned MON_COUNT   = 3;
  // =========================================
  // reset values
  localparam logic [2:0] INDEX_RESET = 3'h0;
  localparam logic [2:0] REF_RESET   = 3'h0;
  localparam logic [7:0] EVENT_IDLE  = 8'hFF;
  localparam logic [2:0] MON_RESET   = 3'h0;
  // =========================================
  // variant select
  typedef enum logic [0:0] {
    WER_VAR_ENCODER = 1'h0,
    WER_VAR_CHANGE  = 1'h1
  } wer_variant_e;
endpackage

/* logic/wer_ref_if.sv */
// interface carrying the captured reference between the top and the reference store
interface wer_ref_if;
  logic       cap_stb;
  logic [2:0] mon;
  logic [2:0] ref_bits;
  modport top (output cap_stb, output mon, input ref_bits);
  modport store (input cap_stb, input mon, output ref_bits);
endinterface

/* logic/wer_ref_store.sv */
// three reference flip-flops loaded on the capture strobe
module wer_ref_store (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  wer_ref_if.store  ref_if
);
  // =========================================
  // reference capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_if.ref_bits <= wer_pkg::REF_RESET;
    end else if (ref_if.cap_stb) begin
      ref_if.ref_bits <= ref_if.mon; // [RULE7]
    end
  end
endmodule

/* logic/wer_top.sv */
// wake event reset detector: priority encoder and change detector variants
//
// Function
// [RULE1] With event inputs low, the index outputs give the highest-numbered low input.
// [RULE2] The any-event flag is high when any event input is low, else low.
// [RULE3] The wake reset pin drives only high or floats.
// [RULE4] Encoder variant enables the wake driver when arm is low and the any-event flag is high.
// [RULE5] The controller drives arm low before power-down.
// [RULE6] After controller reset arm reads high and the wake driver floats.
// [RULE7] Three flip-flops capture the monitored lines on a capture strobe rising edge.
// [RULE8] The controller pulses the capture strobe before power-down.
// [RULE9] Each stored bit is compared with its live line; match is high only when all agree.
// [RULE10] Change variant enables the wake driver when arm is low and match is false.
// [RULE11] Inverted stored bits drive their pins only while the snapshot enable is low.
// [RULE12] With no event low the index reads zero.
module wer_top #(
  parameter int unsigned EVENT_COUNT = wer_pkg::EVENT_COUNT,
  parameter int unsigned MON_COUNT   = wer_pkg::MON_COUNT
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    variant_i,
  input  wire logic [EVENT_COUNT-1:0]  event_in_n_i,
  input  wire logic                    arm_n_i,
  input  wire logic                    capture_i,
  input  wire logic [MON_COUNT-1:0]    mon_i,
  input  wire logic                    ref_oe_n_i,
  output logic [2:0]                   index_o,
  output logic                         any_event_flag_o,
  output logic [MON_COUNT-1:0]         bit_match_o,
  output logic                         match_o,
  output logic                         wake_rst_o,
  output logic                         wake_rst_oe_o,
  output logic [MON_COUNT-1:0]         ref_inv_o,
  output logic [MON_COUNT-1:0]         ref_inv_oe_o
);
  // =========================================
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // =========================================
  // input synchronisers, two stages each
  localparam int unsigned SW = EVENT_COUNT + MON_COUNT + 4;
  logic [SW-1:0] in_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  assign in_raw = {variant_i, arm_n_i, capture_i, ref_oe_n_i, mon_i, event_in_n_i};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= {1'h0, 1'h1, 1'h0, 1'h1, {MON_COUNT{1'h0}}, {EVENT_COUNT{1'h1}}};
      sync2_q <= {1'h0, 1'h1, 1'h0, 1'h1, {MON_COUNT{1'h0}}, {EVENT_COUNT{1'h1}}};
    end else begin
      sync1_q <= in_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [EVENT_COUNT-1:0] ev_n;
  logic [MON_COUNT-1:0]   mon;
  logic                   ref_oe_n;
  logic                   cap_s;
  logic                   arm_n;
  logic                   var_chg;
  assign ev_n      = sync2_q[EVENT_COUNT-1:0];
  assign mon       = sync2_q[EVENT_COUNT +: MON_COUNT];
  assign ref_oe_n  = sync2_q[EVENT_COUNT+MON_COUNT];
  assign cap_s     = sync2_q[EVENT_COUNT+MON_COUNT+1];
  assign arm_n     = sync2_q[EVENT_COUNT+MON_COUNT+2];
  assign var_chg   = sync2_q[EVENT_COUNT+MON_COUNT+3];

  // =========================================
  // capture strobe rising edge
  logic cap_d_q;
  logic cap_rise;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_d_q <= 1'h0;
    end else begin
      cap_d_q <= cap_s;
    end
  end
  assign cap_rise = cap_s & ~cap_d_q;

  // =========================================
  // priority encoder, highest index wins
  logic [2:0] index_d;
  logic       any_d;
  always_comb begin
    index_d = wer_pkg::INDEX_RESET; // [RULE12]
    any_d   = 1'h0;
    for (int i = 0; i < EVENT_COUNT; i++) begin
      if (!ev_n[i]) begin
        index_d = 3'(i); // [RULE1]
        any_d   = 1'h1;  // [RULE2]
      end
    end
  end

  // =========================================
  // reference store and comparator
  wer_ref_if ref_if ();
  assign ref_if.cap_stb = cap_rise;
  assign ref_if.mon     = mon;
  wer_ref_store u_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ref_if  (ref_if)
  );
  logic [MON_COUNT-1:0] bit_eq;
  assign bit_eq = ~(ref_if.ref_bits ^ mon); // [RULE9]

  // =========================================
  // encoder outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      index_o          <= wer_pkg::INDEX_RESET;
      any_event_flag_o <= 1'h0;
    end else begin
      index_o          <= index_d;
      any_event_flag_o <= any_d;
    end
  end

  // comparator outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_match_o <= {MON_COUNT{1'h1}};
      match_o     <= 1'h1;
    end else begin
      bit_match_o <= bit_eq;
      match_o     <= &bit_eq; // [RULE9]
    end
  end

  // wake reset driver: data fixed high, enable gated by arm
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_rst_o    <= 1'h1;
      wake_rst_oe_o <= 1'h0;
    end else begin
      wake_rst_o <= 1'h1; // [RULE3]
      if (var_chg == wer_pkg::WER_VAR_CHANGE) begin
        wake_rst_oe_o <= ~arm_n & ~(&bit_eq); // [RULE10] [RULE6]
      end else begin
        wake_rst_oe_o <= ~arm_n & any_d; // [RULE4] [RULE6]
      end
    end
  end

  // inverted reference pins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_inv_o    <= ~wer_pkg::REF_RESET;
      ref_inv_oe_o <= {MON_COUNT{1'h0}};
    end else begin
      ref_inv_o    <= ~ref_if.ref_bits; // [RULE11]
      ref_inv_oe_o <= {MON_COUNT{~ref_oe_n}}; // [RULE11]
    end
  end
endmodule

/* verification/wer_chk.sv */
// port checker for the wake event reset detector
module wer_chk #(
  parameter int unsigned EVENT_COUNT = 8,
  parameter int unsigned MON_COUNT   = 3
) (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic                   variant_i,
  input wire logic [EVENT_COUNT-1:0] event_in_n_i,
  input wire logic                   arm_n_i,
  input wire logic                   capture_i,
  input wire logic [MON_COUNT-1:0]   mon_i,
  input wire logic                   ref_oe_n_i,
  input wire logic [2:0]             index_o,
  input wire logic                   any_event_flag_o,
  input wire logic [MON_COUNT-1:0]   bit_match_o,
  input wire logic                   match_o,
  input wire logic                   wake_rst_o,
  input wire logic                   wake_rst_oe_o,
  input wire logic [MON_COUNT-1:0]   ref_inv_o,
  input wire logic [MON_COUNT-1:0]   ref_inv_oe_o
);
  // ==========================
  // edges since reset release
  logic [2:0] up_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (up_q != 3'h7);
  flag_follow_a: assert property (any_event_flag_o == ($past(event_in_n_i, 3) != 8'hFF)) else $error("flag");
  index_prio_a: assert property (any_event_flag_o |->
    (($past(event_in_n_i, 3) >> index_o) == ((8'hFF >> index_o) - 8'h1))) else $error("index");
  idle_index_a: assert property (!any_event_flag_o |-> index_o == 3'h0) else $error("idle index");
  wake_data_a: assert property (wake_rst_o) else $error("wake data");
  enc_enable_a: assert property (!$past(variant_i, 3) |->
    wake_rst_oe_o == (!$past(arm_n_i, 3) && any_event_flag_o)) else $error("enc oe");
  chg_enable_a: assert property ($past(variant_i, 3) |->
    wake_rst_oe_o == (!$past(arm_n_i, 3) && !match_o)) else $error("chg oe");
  match_all_a: assert property (match_o == &bit_match_o) else $error("match");
  bit_compare_a: assert property (bit_match_o == (ref_inv_o ^ $past(mon_i, 3))) else $error("bits");
  ref_pin_oe_a: assert property (ref_inv_oe_o == {MON_COUNT{!$past(ref_oe_n_i, 3)}}) else $error("ref pin oe");
  ref_capture_a: assert property ($rose(capture_i) |-> ##4 ref_inv_o == ~$past(mon_i, 4)) else $error("capture");
endmodule
bind wer_top wer_chk #(.EVENT_COUNT(EVENT_COUNT), .MON_COUNT(MON_COUNT)) u_wer_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .variant_i(variant_i), .event_in_n_i(event_in_n_i),
  .arm_n_i(arm_n_i), .capture_i(capture_i), .mon_i(mon_i), .ref_oe_n_i(ref_oe_n_i),
  .index_o(index_o), .any_event_flag_o(any_event_flag_o), .bit_match_o(bit_match_o),
  .match_o(match_o), .wake_rst_o(wake_rst_o), .wake_rst_oe_o(wake_rst_oe_o),
  .ref_inv_o(ref_inv_o), .ref_inv_oe_o(ref_inv_oe_o));

/* verification/wer_ctl_model.sv */
// controller model: arms, captures, and is reset by the wake line
module wer_ctl_model (
  input  wire logic clk_i,
  input  wire logic arm_req_i,
  input  wire logic cap_req_i,
  input  wire logic wake_i,
  input  wire logic wake_oe_i,
  output logic      arm_n_o,
  output logic      capture_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================
  // woken: arm_n_o falls back to a pulled-up input; capture_o still follows cap_req_i
  logic woke_q; // cleared at the first edge while arm_req_i is low
  always_ff @(posedge clk_i) woke_q <= arm_req_i && (woke_q || (wake_oe_i && wake_i));
  assign arm_n_o   = !arm_req_i || woke_q;
  assign capture_o = cap_req_i;
endmodule

/* verification/tb_wer_top.sv */
// testbench of the wake event reset detector
module tb_wer_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================
  // stimulus and observed outputs
  logic       clk_i = 0, resetn_i = 0, variant_i = 0, arm_req = 0, cap_req = 0, ref_oe_n_i = 1;
  logic [7:0] event_in_n_i = 8'hFF;
  logic [2:0] mon_i = 3'h0, index_o, bit_match_o, ref_inv_o, ref_inv_oe_o;
  logic       any_event_flag_o, match_o, wake_rst_o, wake_rst_oe_o, arm_n_i, capture_i;
  int         bad_count = 0, checks = 0;
  // rows: events, flag, index
  logic [11:0] rows [6] = '{12'hFF0, 12'hFE8, 12'h7FF, 12'h00F, 12'hDBD, 12'hF7B};
  always #10 clk_i = ~clk_i;
  wer_top u_wer_top (.clk_i(clk_i), .resetn_i(resetn_i), .variant_i(variant_i), .event_in_n_i(event_in_n_i),
    .arm_n_i(arm_n_i), .capture_i(capture_i), .mon_i(mon_i), .ref_oe_n_i(ref_oe_n_i), .index_o(index_o),
    .any_event_flag_o(any_event_flag_o), .bit_match_o(bit_match_o), .match_o(match_o), .wake_rst_o(wake_rst_o),
    .wake_rst_oe_o(wake_rst_oe_o), .ref_inv_o(ref_inv_o), .ref_inv_oe_o(ref_inv_oe_o));
  wer_ctl_model u_wer_ctl_model (.clk_i(clk_i), .arm_req_i(arm_req), .cap_req_i(cap_req), .wake_i(wake_rst_o),
    .wake_oe_i(wake_rst_oe_o), .arm_n_o(arm_n_i), .capture_o(capture_i));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task close_out();
    $display("bad_count %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #100us;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    step(6);
    chk("oe", 0, wake_rst_oe_o);
    foreach (rows[i]) begin
      @(posedge clk_i) event_in_n_i <= rows[i][11:4];
      step(5);
      chk("index", rows[i][2:0], index_o);
      chk("flag", rows[i][3], any_event_flag_o);
    end
    @(posedge clk_i) event_in_n_i <= 8'hFF;
    arm_req <= 1;
    step(5);
    chk("oe", 0, wake_rst_oe_o);
    @(posedge clk_i) event_in_n_i <= 8'hEF;
    step(4);
    chk("oe", 1, wake_rst_oe_o);
    step(5);
    chk("oe", 0, wake_rst_oe_o);
    // change variant: capture 101, then break the match
    @(posedge clk_i) arm_req <= 0;
    variant_i <= 1;
    mon_i <= 3'h5;
    ref_oe_n_i <= 0;
    @(posedge clk_i) cap_req <= 1;
    repeat (2) @(posedge clk_i);
    cap_req <= 0;
    step(5);
    chk("match", 1, match_o);
    chk("ref_inv", 2, ref_inv_o);
    chk("ref_oe", 7, ref_inv_oe_o);
    @(posedge clk_i) arm_req <= 1;
    step(5);
    chk("oe", 0, wake_rst_oe_o);
    @(posedge clk_i) mon_i <= 3'h4;
    ref_oe_n_i <= 1;
    step(4);
    chk("bits", 6, bit_match_o);
    chk("match", 0, match_o);
    chk("oe", 1, wake_rst_oe_o);
    chk("ref_oe", 0, ref_inv_oe_o);
    // mid-run reset: outputs take reset values at once, reference clears
    @(posedge clk_i) resetn_i <= 0;
    step(1);
    chk("rst index", 0, index_o);
    chk("rst flag", 0, any_event_flag_o);
    chk("rst wake", 1, wake_rst_o);
    chk("rst oe", 0, wake_rst_oe_o);
    chk("rst ref_inv", 7, ref_inv_o);
    @(posedge clk_i) resetn_i <= 1;
    step(6);
    chk("index", 4, index_o);
    chk("wake", 1, wake_rst_o);
    chk("bits", 3, bit_match_o);
    chk("ref_inv", 7, ref_inv_o);
    chk("oe", 0, wake_rst_oe_o);
    close_out();
  end
endmodule
